// ### spsc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
//          for the serial port status and control bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by the bank and any bench that needs the map
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH

// register byte offsets
`define SPSC_OFF_STATCTL 12'h000
`define SPSC_OFF_BUF 12'h004
`define SPSC_OFF_CFG 12'h008
`define SPSC_OFF_IRQ_STAT 12'h00C
`define SPSC_OFF_IRQ_MASK 12'h010

// status and control field positions
`define SPSC_B_ON 15
`define SPSC_B_SIDL 13
`define SPSC_B_BEC_HI 10
`define SPSC_B_BEC_LO 8
`define SPSC_B_SHIFT_REG_EMPTY 7
`define SPSC_B_ROV 6
`define SPSC_B_RXMPT 5
`define SPSC_B_BUFFER_IRQ_SELECT_HI 4
`define SPSC_B_BUFFER_IRQ_SELECT_LO 2
`define SPSC_B_TBF 1
`define SPSC_B_RBF 0

// configuration field positions
`define SPSC_B_MASTER 0
`define SPSC_B_ENH 1

// interrupt status and mask bits
`define SPSC_IRQ_DONE 0
`define SPSC_IRQ_ROV 1
`define SPSC_IRQ_SEL 2
`define SPSC_NIRQ 3

// reset values
`define SPSC_RST_BUFFER_IRQ_SELECT 3'h0
`define SPSC_RST_IRQ_MASK 3'h0
`define SPSC_RST_PRDATA 32'h0000_0000

// buffer interrupt select codes
`define SPSC_SEL_RXEMPTY 3'h0
`define SPSC_SEL_RXAVAIL 3'h1
`define SPSC_SEL_RX3Q 3'h2
`define SPSC_SEL_RXFULL 3'h3
`define SPSC_SEL_TXROOM 3'h4
`define SPSC_SEL_TXDONE 3'h5
`define SPSC_SEL_TXEMPTY 3'h6
`define SPSC_SEL_TXFULL 3'h7

// timing: serial clock half period in ns, and in ref_clk cycles
`define SPSC_CLK_NS 10
`define SPSC_SCK_HALF_NS 80
`define SPSC_SCK_HALF_CYC \
   ((`SPSC_SCK_HALF_NS + `SPSC_CLK_NS - 1) / `SPSC_CLK_NS)

`endif

// ### spsc_pkg.sv
// Purpose: types shared by the serial port status and control bank
// Assumes: nothing beyond the defines header
// Notes:   the shift engine state is the only shared type
package spsc_pkg;
   typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} spsc_state_t;
endpackage

// ### spsc_bank.sv
// Purpose: status/control bank with a small shift engine and buffers
// Assumes: APB slave with zero wait states, mode-0 serial framing
// Notes:   serial pins are sampled by ref_clk through two flip-flops
// Function
// - module-on bit 15 enables the port and hands it the serial pins
// - halt-in-idle bit 13 stops the port while the device idles
// - enhanced master mode: count field 10-8 shows pending transfers
// - enhanced slave mode: count field shows received words still unread
// - bit 7 reads one while the shift register is empty
// - word received with buffer still full sets overflow bit 6, is dropped
// - bits 14 and 12-11 always read zero
// - overflow bit reads zero when no overflow has happened
// - bit 5 reads one while the receive buffer holds nothing
// - three-bit select picks one of eight buffer interrupt conditions
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "spsc_defines.svh"
module spsc_bank #(
   parameter int DW = 8,
   parameter int DEPTH = 4,
   parameter int SCK_HALF = `SPSC_SCK_HALF_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic device_idle,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_n,
   output logic serial_out_pin,
   output logic serial_out_pin_oe_n,
   input wire logic serial_in_pin,
   input wire logic slave_select_pin_n_in,
   output logic slave_select_pin_n_out,
   output logic slave_select_pin_n_oe_n,
   output logic irq
);
   import spsc_pkg::*;
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // refuse sizes the 3-bit count field cannot show
   if (DW < 2 || DW > 32 || DEPTH < 2 || DEPTH > 7 || SCK_HALF < 1 ||
      SCK_HALF > 256) begin
      $error("spsc_bank: unsupported DW, DEPTH or SCK_HALF");
   end

   // wrap a buffer pointer at the buffer depth
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // decode a register offset to a hit
   function automatic logic addr_hit(input logic [11:0] a);
      return a == `SPSC_OFF_STATCTL || a == `SPSC_OFF_BUF ||
         a == `SPSC_OFF_CFG || a == `SPSC_OFF_IRQ_STAT ||
         a == `SPSC_OFF_IRQ_MASK;
   endfunction

   logic port_on, halt_in_idle, receive_overflow_flag;
   logic [2:0] buffer_irq_select;
   logic cfg_master, cfg_enh;
   logic [`SPSC_NIRQ-1:0] irq_stat, irq_mask, irq_ev;
   logic [DW-1:0] tx_mem [DEPTH];
   logic [DW-1:0] rx_mem [DEPTH];
   logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [2:0] tx_cnt, rx_cnt, limit, pending;
   logic sck_s1, sck_s2, sck_s3, ss_s1, ss_s2, ss_s3, sdi_s1, sdi_s2;
   logic sck_rise, sck_fall, ss_fall;
   spsc_state_t state;
   logic sck_out, ss_out_n, xfer_done, run;
   logic [5:0] bit_cnt;
   logic [7:0] half_cnt;
   logic [DW-1:0] tx_sh, rx_sh;
   logic master_start, slave_load, tx_pop, tx_push, rx_push, rx_pop;
   logic rx_ovf, sel_lvl, sel_prev, tx_full_flag, rx_full_flag;
   logic apb_setup, apb_acc, wr_stat, rd_clr_irq;
   logic [15:0] stat_word;
   logic [31:0] rd_val;

   // apb phase decode; zero wait states
   assign pready = 1'b1;
   assign apb_setup = psel && !penable;
   assign apb_acc = psel && penable;
   assign pslverr = apb_acc && !addr_hit(paddr);
   assign wr_stat = apb_acc && pwrite && paddr == `SPSC_OFF_STATCTL;
   assign rd_clr_irq = apb_acc && !pwrite && paddr == `SPSC_OFF_IRQ_STAT;

   // port runs only while on and not halted by idle
   assign run = port_on && !(halt_in_idle && device_idle);

   // pin synchronisers, two flops before any logic
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {ss_s1, ss_s2, ss_s3} <= 3'h7;
         {sdi_s1, sdi_s2} <= 2'h0;
      end else begin
         sck_s1 <= serial_clock_pin_in;
         sck_s2 <= sck_s1;
         sck_s3 <= sck_s2;
         ss_s1 <= slave_select_pin_n_in;
         ss_s2 <= ss_s1;
         ss_s3 <= ss_s2;
         sdi_s1 <= serial_in_pin;
         sdi_s2 <= sdi_s1;
      end
   end
   assign sck_rise = sck_s2 && !sck_s3;
   assign sck_fall = !sck_s2 && sck_s3;
   assign ss_fall = !ss_s2 && ss_s3;

   // buffer limits: one word unless enhanced buffering is on
   assign limit = cfg_enh ? 3'(DEPTH) : 3'h1;
   assign tx_full_flag = tx_cnt >= limit;
   assign rx_full_flag = rx_cnt >= limit;
   assign pending = (tx_cnt == 3'h7 || state == ST_IDLE) ?
      tx_cnt : tx_cnt + 3'h1;

   // engine start and reload requests that pop the transmit buffer
   assign master_start = state == ST_IDLE && run && cfg_master &&
      tx_cnt != 3'h0;
   assign slave_load = run && !cfg_master && tx_cnt != 3'h0 &&
      ((state == ST_IDLE && ss_fall) || (state == ST_SHIFT && sck_rise &&
      !ss_s2 && bit_cnt == 6'(DW - 1)));
   assign tx_pop = master_start || slave_load;
   assign tx_push = apb_acc && pwrite && paddr == `SPSC_OFF_BUF &&
      !tx_full_flag;
   assign rx_push = xfer_done && !rx_full_flag;
   assign rx_ovf = xfer_done && rx_full_flag;
   assign rx_pop = apb_acc && !pwrite && paddr == `SPSC_OFF_BUF &&
      rx_cnt != 3'h0;

   // shift engine: master clock divider or slave edge follower
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         sck_out <= 1'b0;
         ss_out_n <= 1'b1;
         half_cnt <= 8'h00;
         bit_cnt <= 6'h00;
         tx_sh <= '0;
         rx_sh <= '0;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= 1'b0;
         if (!run) begin
            state <= ST_IDLE;
            sck_out <= 1'b0;
            ss_out_n <= 1'b1;
            bit_cnt <= 6'h00;
         end else if (cfg_master) begin
            if (master_start) begin
               state <= ST_SHIFT;
               ss_out_n <= 1'b0;
               tx_sh <= tx_mem[tx_rp];
               half_cnt <= 8'(SCK_HALF - 1);
               bit_cnt <= 6'h00;
            end else if (state == ST_SHIFT) begin
               if (half_cnt != 8'h00) begin
                  half_cnt <= half_cnt - 8'h01;
               end else begin
                  half_cnt <= 8'(SCK_HALF - 1);
                  sck_out <= !sck_out;
                  if (!sck_out) begin
                     rx_sh <= {rx_sh[DW-2:0], sdi_s2};
                     bit_cnt <= bit_cnt + 6'h01;
                  end else if (bit_cnt == 6'(DW)) begin
                     state <= ST_IDLE;
                     ss_out_n <= 1'b1;
                     xfer_done <= 1'b1;
                  end else begin
                     tx_sh <= {tx_sh[DW-2:0], 1'b0};
                  end
               end
            end
         end else begin
            if (state == ST_IDLE && ss_fall) begin
               state <= ST_SHIFT;
               bit_cnt <= 6'h00;
               tx_sh <= slave_load ? tx_mem[tx_rp] : '0;
            end else if (state == ST_SHIFT && ss_s2) begin
               state <= ST_IDLE;
            end else if (state == ST_SHIFT && sck_rise) begin
               rx_sh <= {rx_sh[DW-2:0], sdi_s2};
               if (bit_cnt == 6'(DW - 1)) begin
                  bit_cnt <= 6'h00;
                  xfer_done <= 1'b1;
                  tx_sh <= slave_load ? tx_mem[tx_rp] : '0;
               end else begin
                  bit_cnt <= bit_cnt + 6'h01;
               end
            end else if (state == ST_SHIFT && sck_fall &&
               bit_cnt != 6'h00) begin
               tx_sh <= {tx_sh[DW-2:0], 1'b0};
            end
         end
      end
   end

   // transmit buffer pointers and count
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_cnt <= 3'h0;
      end else begin
         if (tx_push) tx_wp <= ptr_inc(tx_wp);
         if (tx_pop) tx_rp <= ptr_inc(tx_rp);
         tx_cnt <= tx_cnt + 3'(tx_push) - 3'(tx_pop);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (tx_push) tx_mem[tx_wp] <= pwdata[DW-1:0];
   end

   // receive buffer; a word arriving when full is dropped
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_cnt <= 3'h0;
      end else begin
         if (rx_push) rx_wp <= ptr_inc(rx_wp);
         if (rx_pop) rx_rp <= ptr_inc(rx_rp);
         rx_cnt <= rx_cnt + 3'(rx_push) - 3'(rx_pop);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rx_push) rx_mem[rx_wp] <= rx_sh;
   end

   // control fields written by software
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_on <= 1'b0;
         halt_in_idle <= 1'b0;
         buffer_irq_select <= `SPSC_RST_BUFFER_IRQ_SELECT;
         cfg_master <= 1'b0;
         cfg_enh <= 1'b0;
         irq_mask <= `SPSC_RST_IRQ_MASK;
      end else if (apb_acc && pwrite) begin
         if (paddr == `SPSC_OFF_STATCTL) begin
            port_on <= pwdata[`SPSC_B_ON];
            halt_in_idle <= pwdata[`SPSC_B_SIDL];
            buffer_irq_select <= pwdata[`SPSC_B_BUFFER_IRQ_SELECT_HI:`SPSC_B_BUFFER_IRQ_SELECT_LO];
         end
         if (paddr == `SPSC_OFF_CFG) begin
            cfg_master <= pwdata[`SPSC_B_MASTER];
            cfg_enh <= pwdata[`SPSC_B_ENH];
         end
         if (paddr == `SPSC_OFF_IRQ_MASK) irq_mask <= pwdata[`SPSC_NIRQ-1:0];
      end
   end

   // overflow flag: set wins, cleared by writing zero
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         receive_overflow_flag <= 1'b0;
      end else if (rx_ovf) begin
         receive_overflow_flag <= 1'b1;
      end else if (wr_stat && !pwdata[`SPSC_B_ROV]) begin
         receive_overflow_flag <= 1'b0;
      end
   end

   // buffer interrupt condition chosen by the select field
   always_comb begin
      unique case (buffer_irq_select)
         `SPSC_SEL_TXFULL: sel_lvl = tx_full_flag;
         `SPSC_SEL_TXEMPTY: sel_lvl = tx_cnt == 3'h0 && state == ST_SHIFT;
         `SPSC_SEL_TXDONE: sel_lvl = tx_cnt == 3'h0 && state == ST_IDLE;
         `SPSC_SEL_TXROOM: sel_lvl = !tx_full_flag;
         `SPSC_SEL_RXFULL: sel_lvl = rx_full_flag;
         // five bits hold 7*4 without wrapping
         `SPSC_SEL_RX3Q: sel_lvl = 5'(rx_cnt) * 5'h04 >= 5'(limit) * 5'h03;
         `SPSC_SEL_RXAVAIL: sel_lvl = rx_cnt != 3'h0;
         `SPSC_SEL_RXEMPTY: sel_lvl = rx_cnt == 3'h0;
      endcase
   end
   assign irq_ev = {sel_lvl && !sel_prev, rx_ovf, xfer_done};

   // sticky event bits; read clears only what was returned
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat <= '0;
         sel_prev <= 1'b0;
      end else begin
         sel_prev <= sel_lvl;
         irq_stat <= (irq_stat & ~(rd_clr_irq ? prdata[`SPSC_NIRQ-1:0] :
            '0)) | irq_ev;
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // status word; unimplemented bits stay zero
   always_comb begin
      stat_word = 16'h0000;
      stat_word[`SPSC_B_ON] = port_on;
      stat_word[`SPSC_B_SIDL] = halt_in_idle;
      stat_word[`SPSC_B_BEC_HI:`SPSC_B_BEC_LO] =
         cfg_master ? pending : rx_cnt;
      stat_word[`SPSC_B_SHIFT_REG_EMPTY] = state == ST_IDLE;
      stat_word[`SPSC_B_ROV] = receive_overflow_flag;
      stat_word[`SPSC_B_RXMPT] = rx_cnt == 3'h0;
      stat_word[`SPSC_B_BUFFER_IRQ_SELECT_HI:`SPSC_B_BUFFER_IRQ_SELECT_LO] = buffer_irq_select;
      stat_word[`SPSC_B_TBF] = tx_full_flag;
      stat_word[`SPSC_B_RBF] = rx_full_flag;
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         `SPSC_OFF_STATCTL: rd_val = {16'h0000, stat_word};
         `SPSC_OFF_BUF: rd_val = 32'(rx_mem[rx_rp]);
         `SPSC_OFF_CFG: rd_val = 32'({cfg_enh, cfg_master});
         `SPSC_OFF_IRQ_STAT: rd_val = 32'(irq_stat);
         `SPSC_OFF_IRQ_MASK: rd_val = 32'(irq_mask);
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup phase, stable through access
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= `SPSC_RST_PRDATA;
      end else if (apb_setup && !pwrite) begin
         prdata <= rd_val;
      end
   end

   // pins released unless the port is on
   assign serial_clock_pin_out = sck_out;
   assign serial_clock_pin_oe_n = !(port_on && cfg_master);
   assign serial_out_pin = tx_sh[DW-1];
   assign serial_out_pin_oe_n = !(port_on && (cfg_master || !ss_s2));
   assign slave_select_pin_n_out = ss_out_n;
   assign slave_select_pin_n_oe_n = !(port_on && cfg_master);

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic stat_rd;
   assign stat_rd = apb_setup && !pwrite && paddr == `SPSC_OFF_STATCTL;
   sequence s_txfull_rise;
      buffer_irq_select == `SPSC_SEL_TXFULL && tx_full_flag &&
         !$past(tx_full_flag);
   endsequence
   sequence s_irq_set;
      ##1 irq_stat[`SPSC_IRQ_SEL];
   endsequence

   property p_off_releases;
      !port_on |-> serial_clock_pin_oe_n && serial_out_pin_oe_n;
   endproperty
   a_off_releases: assert property (p_off_releases)
      else $error("pins driven while port off");
   property p_idle_halt;
      halt_in_idle && device_idle && state == ST_IDLE |=> state == ST_IDLE;
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("port ran while halted in idle");
   property p_bec_master;
      stat_rd && cfg_master |=> prdata[10:8] == $past(pending);
   endproperty
   a_bec_master: assert property (p_bec_master)
      else $error("pending count wrong");
   property p_bec_slave;
      stat_rd && !cfg_master |=> prdata[10:8] == $past(rx_cnt);
   endproperty
   a_bec_slave: assert property (p_bec_slave)
      else $error("unread count wrong");
   property p_shift_reg_empty;
      stat_rd |=> prdata[7] == $past(state == ST_IDLE);
   endproperty
   a_shift_reg_empty: assert property (p_shift_reg_empty)
      else $error("shift empty bit wrong");
   property p_ovf;
      xfer_done && rx_full_flag |=> receive_overflow_flag &&
         rx_cnt == $past(rx_cnt) - 3'($past(rx_pop));
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not flagged or data kept");
   property p_unimpl;
      stat_rd |=> prdata[14] == 1'b0 && prdata[12:11] == 2'h0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented bits not zero");
   property p_no_ovf;
      !receive_overflow_flag && !xfer_done |=> !receive_overflow_flag;
   endproperty
   a_no_ovf: assert property (p_no_ovf)
      else $error("overflow set without cause");
   property p_rxmpt;
      stat_rd |=> prdata[5] == $past(rx_cnt == 3'h0);
   endproperty
   a_rxmpt: assert property (p_rxmpt)
      else $error("rx empty bit wrong");
   property p_sel_txfull;
      s_txfull_rise |-> s_irq_set;
   endproperty
   a_sel_txfull: assert property (p_sel_txfull)
      else $error("select condition not flagged");
   property p_ovf_sticky;
      receive_overflow_flag && !(wr_stat && !pwdata[6]) |=>
         receive_overflow_flag;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky)
      else $error("overflow cleared without software");
endmodule

// ### spsc_far_model.sv
// Purpose: far-side serial device for the status/control bench
// Assumes: mode 0, msb first, 8-bit words, 80 ns half period
// Notes:   slave while the port drives select, master via task
`timescale 1ns/10ps
module spsc_far_model (
   input wire logic sck_w,
   input wire logic ss_n_w,
   input wire logic sdo,
   input wire logic ss_oe_n,
   input wire logic [7:0] reply,
   output logic m_sck,
   output logic m_ss_n,
   output logic sdi,
   output logic [7:0] rx_word,
   output int rx_cnt
);
   logic [7:0] sh;
   logic [7:0] cap;
   logic busy;
   logic driving;
   // idle: link clock still, select released high
   initial begin
      m_sck = 1'b0;
      m_ss_n = 1'b1;
      sdi = 1'b0;
      busy = 1'b0;
      driving = 1'b0;
      rx_cnt = 0;
      rx_word = 8'h00;
   end
   // unselected data line churns so stale bits never look valid
   always #13 if (!busy && !driving && ss_n_w) sdi = ~sdi;
   // slave role: reply goes out msb first once selected
   always @(negedge ss_n_w) if (!ss_oe_n) begin
      busy = 1'b1;
      sh = reply;
      sdi = sh[7];
   end
   // capture on the rising edge, shift on the falling edge
   always @(posedge sck_w) if (busy && !ss_oe_n) cap = {cap[6:0], sdo};
   always @(negedge sck_w) if (busy && !ss_oe_n) begin
      sh = {sh[6:0], 1'b0};
      sdi = sh[7];
   end
   // frame end hands over the word; a released select drops it
   always @(posedge ss_n_w) if (busy) begin
      if (!ss_oe_n) begin
         rx_word = cap;
         rx_cnt++;
      end
      busy = 1'b0;
   end
   // master role: one framed word at 160 ns per bit
   task automatic master_word(input logic [7:0] b);
      driving = 1'b1;
      m_ss_n = 1'b0;
      sdi = b[7];
      #80;
      for (int i = 7; i >= 0; i--) begin
         m_sck = 1'b1;
         #80;
         m_sck = 1'b0;
         if (i > 0) sdi = b[i-1];
         #80;
      end
      m_ss_n = 1'b1;
      #160;
      driving = 1'b0;
   endtask
endmodule

// ### spi_status_control_bank_tb_top.sv
// Purpose: self-checking bench for the serial status/control bank
// Assumes: default shift timing, far-side model on the serial pins
// Notes:   random bytes from a fixed seed, corner cases by hand
`timescale 1ns/10ps
`include "spsc_defines.svh"
module spi_status_control_bank_tb_top;
   localparam logic [11:0] CTL = `SPSC_OFF_STATCTL;
   localparam logic [11:0] BUF = `SPSC_OFF_BUF;
   localparam logic [11:0] CFG = `SPSC_OFF_CFG;
   localparam logic [11:0] IST = `SPSC_OFF_IRQ_STAT;
   localparam logic [11:0] MSK = `SPSC_OFF_IRQ_MASK;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic device_idle = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, irq, serial_in_pin, m_sck, m_ss_n;
   logic serial_clock_pin_out, serial_clock_pin_oe_n, serial_out_pin;
   logic serial_out_pin_oe_n, slave_select_pin_n_out;
   logic slave_select_pin_n_oe_n;
   logic [7:0] reply = 8'h00;
   logic [7:0] rx_word;
   logic [31:0] rdv;
   logic errv;
   int rx_cnt;
   int error_cnt = 0;
   int checks_done = 0;
   int seed;
   // pin levels: whoever enables wins, else the far side
   wire sck_w = !serial_clock_pin_oe_n ? serial_clock_pin_out : m_sck;
   wire ss_w = !slave_select_pin_n_oe_n ? slave_select_pin_n_out : m_ss_n;
   // 100 MHz system clock
   always #5 ref_clk = ~ref_clk;
   spsc_bank u_spsc_bank (
      .ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .device_idle,
      .serial_clock_pin_in(sck_w), .serial_clock_pin_out,
      .serial_clock_pin_oe_n, .serial_out_pin, .serial_out_pin_oe_n,
      .serial_in_pin, .slave_select_pin_n_in(ss_w),
      .slave_select_pin_n_out, .slave_select_pin_n_oe_n, .irq
   );
   spsc_far_model u_spsc_far_model (
      .sck_w, .ss_n_w(ss_w), .sdo(serial_out_pin),
      .ss_oe_n(slave_select_pin_n_oe_n), .reply, .m_sck, .m_ss_n,
      .sdi(serial_in_pin), .rx_word, .rx_cnt
   );
   // expected control word from its fields
   function automatic logic [31:0] ctl(input logic on, input logic hi,
                                       input logic [2:0] sel);
      ctl = {16'h0000, on, 1'b0, hi, 8'h00, sel, 2'b00};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // one apb transfer: setup, access held until pready
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // poll until nothing pending and the shifter is empty
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         rd(CTL);
         n++;
      end while (!(rdv[10:8] === 3'h0 && rdv[7] === 1'b1) && n < 300);
      chk("idle", 1, n < 300);
   endtask
   task automatic test_master;
      logic [7:0] b0, b1, r;
      int c0;
      wr(CFG, 32'h0000_0003);
      wr(CTL, ctl(1, 0, 0));
      tick(2);
      chk("clk_oe_n", 0, serial_clock_pin_oe_n);
      chk("sel_oe_n", 0, slave_select_pin_n_oe_n);
      chk("sdo_oe_n", 0, serial_out_pin_oe_n);
      for (int k = 0; k < 3; k++) begin
         b0 = 8'($urandom);
         b1 = 8'($urandom);
         r = 8'($urandom);
         reply <= r;
         c0 = rx_cnt;
         wr(BUF, {24'h00_0000, b0});
         wr(BUF, {24'h00_0000, b1});
         rd(CTL);
         chk("pending", 2, rdv[10:8]);
         chk("shift_empty", 0, rdv[7]);
         wait_idle;
         chk("rx_nonempty", 0, rdv[5]);
         chk("far_cnt", c0 + 2, rx_cnt);
         chk("far_word", b1, rx_word);
         rd(BUF);
         chk("rx0", r, rdv);
         rd(BUF);
         chk("rx1", r, rdv);
         rd(CTL);
         chk("rx_empty", 1, rdv[5]);
      end
      $display("test master done");
   endtask
   task automatic test_irq;
      wr(MSK, 32'h0000_0001);
      tick(1);
      chk("irq_on", 1, irq);
      wr(MSK, 32'h0000_0000);
      tick(1);
      chk("irq_masked", 0, irq);
      rd(IST);
      chk("done_bit", 1, rdv[0]);
      wr(MSK, 32'h0000_0001);
      tick(1);
      chk("irq_cleared", 0, irq);
      $display("test irq done");
   endtask
   task automatic test_halt;
      wr(CTL, 32'h0000_0000);
      tick(2);
      chk("off_oe_n", 1, serial_clock_pin_oe_n);
      wr(CTL, ctl(1, 1, 3'h7));
      device_idle <= 1'b1;
      // fill the transmit buffer while halted; nothing may leave
      for (int k = 0; k < 4; k++) wr(BUF, 32'h0000_003C);
      tick(40);
      chk("halt_oe_n", 0, serial_clock_pin_oe_n);
      chk("halt_clk", 0, serial_clock_pin_out);
      rd(CTL);
      chk("halt_pend", 4, rdv[10:8]);
      chk("tx_full", 1, rdv[1]);
      rd(IST);
      chk("sel_txfull", 1, rdv[2]);
      wr(CTL, ctl(1, 0, 0));
      tick(2);
      chk("run_oe_n", 0, serial_clock_pin_oe_n);
      wait_idle;
      chk("idle_word", 8'h3C, rx_word);
      device_idle <= 1'b0;
      $display("test halt done");
   endtask
   task automatic test_slave;
      logic [7:0] a;
      a = 8'($urandom);
      wr(CFG, 32'h0000_0000);
      wr(CTL, ctl(1, 0, 0));
      wr(MSK, 32'h0000_0002);
      u_spsc_far_model.master_word(a);
      u_spsc_far_model.master_word(~a);
      tick(10);
      chk("irq_ovf", 1, irq);
      rd(CTL);
      chk("ovf_set", 1, rdv[6]);
      rd(BUF);
      chk("kept", a, rdv);
      rd(CTL);
      chk("ovf_held", 1, rdv[6]);
      wr(CTL, ctl(1, 0, 0));
      rd(CTL);
      chk("ovf_clear", 0, rdv[6]);
      rd(IST);
      chk("ist_ovf", 1, rdv[1]);
      tick(1);
      chk("irq_off", 0, irq);
      wr(CFG, 32'h0000_0002);
      wr(CTL, ctl(1, 0, 3'h1));
      rd(IST);
      wr(MSK, 32'h0000_0004);
      tick(1);
      chk("sel_idle", 0, irq);
      u_spsc_far_model.master_word(a);
      u_spsc_far_model.master_word(~a);
      tick(10);
      chk("sel_irq", 1, irq);
      rd(CTL);
      chk("unread", 2, rdv[10:8]);
      rd(BUF);
      chk("slv0", a, rdv);
      rd(BUF);
      chk("slv1", 8'(~a), rdv);
      for (int c = 0; c < 8; c++) begin
         wr(CTL, ctl(1, 0, c[2:0]));
         rd(CTL);
         chk("sel_code", c, rdv[4:2]);
      end
      wr(CTL, 32'hFFFF_FFBF);
      rd(CTL);
      chk("reserved", 0, rdv & 32'hFFFF_5800);
      $display("test slave done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #600000;
      error_cnt++;
      close_out;
   end
   // main sequence; a second reset sits between the two halves
   initial begin
      seed = $urandom(32'hE725);
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(CTL);
      chk("rst_reserved", 0, rdv & 32'hFFFF_5800);
      chk("rst_ovf", 0, rdv[6]);
      chk("rst_oe_n", 1, slave_select_pin_n_oe_n);
      chk("rst_sdo_oe_n", 1, serial_out_pin_oe_n);
      rd(12'h0FC);
      chk("unmapped_err", 1, errv);
      chk("unmapped_data", 0, rdv);
      $display("test reset done");
      test_master;
      test_irq;
      test_halt;
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      test_slave;
      close_out;
   end
endmodule
